// ==== design/fractional_gapped_clock_control.sv ====
/*
 Common control for fractional links: gapped channel clocks, cell bus clock
 choice, interrupt disable, multiframe sync source, user pins, level field.
 Assumes a synchronous byte register port on core_clk and line pins that are
 asynchronous to core_clk; the per-channel selection comes from outside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fgc_params.svh"
module fractional_gapped_clock_control #(
    parameter int T1_BITS = `FGC_T1_FRAME_BITS,
    parameter int E1_BITS = `FGC_E1_FRAME_BITS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire fgc_pkg::reg_byte_t reg_wdata,
    output fgc_pkg::reg_byte_t reg_rdata,
    // Line pins
    input wire logic rx_line_clock,
    input wire logic tx_line_clock,
    input wire logic rx_frame_sync,
    input wire logic tx_frame_sync,
    input wire fgc_pkg::line_mode_t line_mode,
    // Per-channel selection
    input wire logic rx_chan_select,
    input wire logic tx_chan_select,
    output logic [4:0] rx_next_channel,
    output logic [4:0] tx_next_channel,
    // Channel clock pins
    output logic rx_channel_clock_pin,
    output logic tx_channel_clock_pin,
    // Cell bus clocks
    input wire logic rx_framer_gated_clock,
    input wire logic tx_framer_gated_clock,
    output logic rx_cell_bus_clock,
    output logic tx_cell_bus_clock,
    // Interrupt
    input wire logic irq_pending,
    output logic irq_out_n,
    // Multiframe sync
    input wire logic es_mf_sync,
    input wire logic framer_mf_sync,
    input wire logic tx_sync_pin,
    output logic tx_mf_sync,
    // User pins and level threshold
    output logic user_out_bit0,
    output logic user_out_bit1,
    output logic user_out_bit2,
    output logic user_out_bit3,
    output logic [3:0] rx_level_thresh
);
    import fgc_pkg::*;

    localparam int NPIN = 7;

    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] meta_reg, meta_next;
    logic [NPIN-1:0] sync_reg, sync_next;
    logic [1:0] lclk_prev_reg, lclk_prev_next;
    logic rx_lclk, tx_lclk, rx_fs, tx_fs, rx_gclk, tx_gclk, sync_pin;
    logic rx_rise, tx_rise;

    reg_byte_t gcc_reg, gcc_next;
    reg_byte_t uoc_reg, uoc_next;
    reg_byte_t rdata_reg, rdata_next;

    logic rx_cell_reg, rx_cell_next;
    logic tx_cell_reg, tx_cell_next;
    logic irq_n_reg, irq_n_next;
    logic mfs_reg, mfs_next;
    logic [3:0] uout_reg, uout_next;
    logic [3:0] rlt_reg, rlt_next;

    cell_clk_src_t rx_src, tx_src;
    mf_src_t mf_src;

    // Register decode shared by the write and the read path.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction

    // The seven line, gated clock and sync pins cross two flip-flops before any logic reads them; line_mode is read directly.
    assign pins = {tx_sync_pin, tx_framer_gated_clock, rx_framer_gated_clock,
                   tx_frame_sync, rx_frame_sync, tx_line_clock, rx_line_clock};

    always_comb begin
        meta_next = pins;
        sync_next = meta_reg;
        lclk_prev_next = sync_reg[1:0];
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            lclk_prev_reg <= 2'h0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            lclk_prev_reg <= lclk_prev_next;
        end
    end

    assign rx_lclk = sync_reg[0];
    assign tx_lclk = sync_reg[1];
    assign rx_fs = sync_reg[2];
    assign tx_fs = sync_reg[3];
    assign rx_gclk = sync_reg[4];
    assign tx_gclk = sync_reg[5];
    assign sync_pin = sync_reg[6];
    assign rx_rise = rx_lclk && !lclk_prev_reg[0];
    assign tx_rise = tx_lclk && !lclk_prev_reg[1];

    // Register file; reads return the state held before a same-cycle write.
    always_comb begin
        gcc_next = gcc_reg;
        uoc_next = uoc_reg;
        rdata_next = rdata_reg;
        if (reg_write) begin
            if (hit(reg_addr, `FGC_GCC_OFFSET)) begin
                gcc_next = reg_wdata;
            end else if (hit(reg_addr, `FGC_UOC_OFFSET)) begin
                uoc_next = reg_wdata;
            end
        end
        if (reg_read) begin
            if (hit(reg_addr, `FGC_GCC_OFFSET)) begin
                rdata_next = gcc_reg;
            end else if (hit(reg_addr, `FGC_UOC_OFFSET)) begin
                rdata_next = uoc_reg;
            end else begin
                rdata_next = `FGC_UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gcc_reg <= `FGC_GCC_RESET;
            uoc_reg <= `FGC_UOC_RESET;
            rdata_reg <= `FGC_UNMAPPED_READ;
        end else begin
            gcc_reg <= gcc_next;
            uoc_reg <= uoc_next;
            rdata_reg <= rdata_next;
        end
    end

    // Output steering. The cell bus clocks are resampled copies, so they
    // carry up to one core cycle of jitter relative to the pins.
    always_comb begin
        rx_src = cell_clk_src_t'(gcc_reg[`FGC_RX_CELL_SEL_BIT]);
        tx_src = cell_clk_src_t'(gcc_reg[`FGC_TX_CELL_SEL_BIT]);
        mf_src = mf_src_t'(gcc_reg[`FGC_MF_SRC_BIT]);
        rx_cell_next = (rx_src == SRC_LINE) ? rx_lclk : rx_gclk;
        tx_cell_next = (tx_src == SRC_LINE) ? tx_lclk : tx_gclk;
        irq_n_next = !(irq_pending && !gcc_reg[`FGC_IRQ_DIS_BIT]);
        // Bit 7 at 0 is only sensible with hardware signalling on.
        mfs_next = (mf_src == MFS_FRAMER) ? (framer_mf_sync || sync_pin) : es_mf_sync;
        uout_next = uoc_reg[`FGC_UOUT_LSB +: 4];
        rlt_next = uoc_reg[`FGC_RLT_LSB +: 4];
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_cell_reg <= 1'b0;
            tx_cell_reg <= 1'b0;
            irq_n_reg <= 1'b1;
            mfs_reg <= 1'b0;
            uout_reg <= 4'h0;
            rlt_reg <= 4'h0;
        end else begin
            rx_cell_reg <= rx_cell_next;
            tx_cell_reg <= tx_cell_next;
            irq_n_reg <= irq_n_next;
            mfs_reg <= mfs_next;
            uout_reg <= uout_next;
            rlt_reg <= rlt_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign rx_cell_bus_clock = rx_cell_reg;
    assign tx_cell_bus_clock = tx_cell_reg;
    assign irq_out_n = irq_n_reg;
    assign tx_mf_sync = mfs_reg;
    assign user_out_bit0 = uout_reg[0];
    assign user_out_bit1 = uout_reg[1];
    assign user_out_bit2 = uout_reg[2];
    assign user_out_bit3 = uout_reg[3];
    assign rx_level_thresh = rlt_reg;

    // Receive and transmit paths are fully independent generators.
    gap_clock_gen #(
        .T1_BITS(T1_BITS),
        .E1_BITS(E1_BITS)
    ) rx_gen (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .line_clk_level(rx_lclk),
        .line_clk_rise(rx_rise),
        .frame_start(rx_fs),
        .line_mode(line_mode),
        .gap_enable(gcc_reg[`FGC_RX_GAP_EN_BIT]),
        .fmt_56k(gcc_reg[`FGC_RX_FMT_BIT]),
        .chan_select(rx_chan_select),
        .next_channel(rx_next_channel),
        .chan_clock(rx_channel_clock_pin)
    );

    gap_clock_gen #(
        .T1_BITS(T1_BITS),
        .E1_BITS(E1_BITS)
    ) tx_gen (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .line_clk_level(tx_lclk),
        .line_clk_rise(tx_rise),
        .frame_start(tx_fs),
        .line_mode(line_mode),
        .gap_enable(gcc_reg[`FGC_TX_GAP_EN_BIT]),
        .fmt_56k(gcc_reg[`FGC_TX_FMT_BIT]),
        .chan_select(tx_chan_select),
        .next_channel(tx_next_channel),
        .chan_clock(tx_channel_clock_pin)
    );

    AST_GCC_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_write && reg_addr == 8'h72 |=> gcc_reg == $past(reg_wdata))
        else $error("gapped clock control write not stored");
    AST_UOUT_FOLLOW: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_write && reg_addr == 8'h73 |-> ##2
        {user_out_bit3, user_out_bit2, user_out_bit1, user_out_bit0} == $past(reg_wdata[3:0], 2))
        else $error("user pins do not follow the written bits");
    AST_RLT_FOLLOW: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_write && reg_addr == 8'h73 |-> ##2 rx_level_thresh == $past(reg_wdata[7:4], 2))
        else $error("level threshold does not follow the written bits");
    AST_IRQ_BLOCKED: assert property (@(posedge core_clk) disable iff (!reset_n)
        gcc_reg[6] |=> irq_out_n)
        else $error("interrupt driven while globally disabled");
    AST_IRQ_PASSED: assert property (@(posedge core_clk) disable iff (!reset_n)
        !gcc_reg[6] && irq_pending |=> !irq_out_n)
        else $error("interrupt lost while enabled");
    AST_MF_ELASTIC: assert property (@(posedge core_clk) disable iff (!reset_n)
        !gcc_reg[7] |=> tx_mf_sync == $past(es_mf_sync))
        else $error("multiframe sync not from elastic store");
    AST_RX_CELL_LINE: assert property (@(posedge core_clk) disable iff (!reset_n)
        gcc_reg[4] |=> rx_cell_bus_clock == $past(sync_reg[0]))
        else $error("receive cell bus clock not the line clock");
    AST_TX_CELL_GATED: assert property (@(posedge core_clk) disable iff (!reset_n)
        !gcc_reg[5] |=> tx_cell_bus_clock == $past(sync_reg[5]))
        else $error("transmit cell bus clock not the gated clock");
endmodule
`default_nettype wire

// ==== pkg/fgc_params.svh ====
/*
 Register offsets, field positions, reset values and frame lengths of the
 fractional gapped clock control block. Guarded, so it may be included more than once.
*/
`ifndef FGC_PARAMS_SVH
`define FGC_PARAMS_SVH

`define FGC_GCC_OFFSET 8'h72
`define FGC_UOC_OFFSET 8'h73
`define FGC_GCC_RESET 8'h00
`define FGC_UOC_RESET 8'h00
`define FGC_UNMAPPED_READ 8'h00

`define FGC_RX_GAP_EN_BIT 0
`define FGC_RX_FMT_BIT 1
`define FGC_TX_GAP_EN_BIT 2
`define FGC_TX_FMT_BIT 3
`define FGC_RX_CELL_SEL_BIT 4
`define FGC_TX_CELL_SEL_BIT 5
`define FGC_IRQ_DIS_BIT 6
`define FGC_MF_SRC_BIT 7

`define FGC_UOUT_LSB 0
`define FGC_RLT_LSB 4

`define FGC_T1_FRAME_BITS 193
`define FGC_E1_FRAME_BITS 256
`define FGC_CHAN_LSB_POS 3'h7

`endif

// ==== pkg/fgc_pkg.sv ====
/*
 Types shared by the fractional gapped clock control block.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package fgc_pkg;
    typedef enum logic {MODE_E1, MODE_T1} line_mode_t;
    typedef enum logic {SRC_GATED, SRC_LINE} cell_clk_src_t;
    typedef enum logic {MFS_ELASTIC, MFS_FRAMER} mf_src_t;
    typedef logic [7:0] reg_byte_t;
endpackage
`default_nettype wire

// ==== design/gap_clock_gen.sv ====
/*
 One direction of the gapped channel clock: counts line bits in the frame,
 latches the per-channel selection and shapes the channel clock pin.
 Assumes line clock level, rise and frame start are already synchronised.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fgc_params.svh"
module gap_clock_gen #(
    parameter int T1_BITS = `FGC_T1_FRAME_BITS,
    parameter int E1_BITS = `FGC_E1_FRAME_BITS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Synchronised line timing
    input wire logic line_clk_level,
    input wire logic line_clk_rise,
    input wire logic frame_start,
    input wire fgc_pkg::line_mode_t line_mode,
    // Control
    input wire logic gap_enable,
    input wire logic fmt_56k,
    input wire logic chan_select,
    // Results
    output logic [4:0] next_channel,
    output logic chan_clock
);
    import fgc_pkg::*;

    logic [8:0] bit_reg, bit_next;
    logic sel_reg, sel_next;
    logic [4:0] nch_reg, nch_next;
    logic clk_reg, clk_next;
    logic [8:0] last_bit;
    logic [8:0] upcoming;
    logic [7:0] pay_next;
    logic [7:0] pay_up;
    logic fbit_next;

    // Position of a bit within the 256-bit payload; T1 loses its framing bit.
    function automatic logic [7:0] payload_pos(input logic [8:0] pos, input line_mode_t mode);
        payload_pos = (mode == MODE_T1) ? 8'(pos - 9'h001) : pos[7:0];
    endfunction

    always_comb begin
        last_bit = (line_mode == MODE_T1) ? 9'(T1_BITS - 1) : 9'(E1_BITS - 1);
        bit_next = bit_reg;
        sel_next = sel_reg;
        if (line_clk_rise) begin
            if (frame_start || bit_reg == last_bit) begin
                bit_next = 9'h000;
            end else begin
                bit_next = bit_reg + 9'h001;
            end
        end
        pay_next = payload_pos(bit_next, line_mode);
        fbit_next = (line_mode == MODE_T1) && (bit_next == 9'h000);
        // The selection is taken only as a channel begins, so it is steady for all its bits.
        if (line_clk_rise && !fbit_next && pay_next[2:0] == 3'h0) begin
            sel_next = chan_select;
        end
        upcoming = (bit_reg == last_bit) ? 9'h000 : bit_reg + 9'h001;
        pay_up = payload_pos(upcoming, line_mode);
        nch_next = pay_up[7:3];
        if (gap_enable) begin
            // No pulse for the framing bit, unselected channels or the 56k LSB.
            clk_next = line_clk_level && sel_next && !fbit_next
                && !(fmt_56k && pay_next[2:0] == `FGC_CHAN_LSB_POS);
        end else begin
            // Ordinary function: one pulse on the first bit of every channel.
            clk_next = line_clk_level && !fbit_next && pay_next[2:0] == 3'h0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_reg <= 9'h000;
            sel_reg <= 1'b0;
            nch_reg <= 5'h00;
            clk_reg <= 1'b0;
        end else begin
            bit_reg <= bit_next;
            sel_reg <= sel_next;
            nch_reg <= nch_next;
            clk_reg <= clk_next;
        end
    end

    assign next_channel = nch_reg;
    assign chan_clock = clk_reg;

    AST_NO_FBIT_PULSE: assert property (@(posedge core_clk) disable iff (!reset_n)
        gap_enable && line_mode == MODE_T1 && line_clk_rise && bit_next == 9'h000
        |-> ##1 !chan_clock [*3])
        else $error("gapped clock pulsed in the framing bit");
    AST_NO_LSB_56K: assert property (@(posedge core_clk) disable iff (!reset_n)
        gap_enable && fmt_56k && pay_next[2:0] == 3'h7 && !fbit_next |=> !chan_clock)
        else $error("gapped clock pulsed on a 56k channel LSB");
    AST_UNSELECTED_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
        gap_enable && !sel_next |=> !chan_clock)
        else $error("gapped clock pulsed in an unselected channel");
    AST_SEL_STEADY: assert property (@(posedge core_clk) disable iff (!reset_n)
        line_clk_rise && pay_next[2:0] != 3'h0 |=> $stable(sel_reg))
        else $error("channel selection changed inside a channel");
endmodule
`default_nettype wire

// ==== test/serial_ctrl_model.sv ====
/*
 Behavioural serial controller that sits on the gapped channel clocks and
 counts the bits it would take in a window that the bench clears.
 Assumes the channel clock pins are registered on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_ctrl_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Gapped bit clocks and window clear
    input wire logic rx_bit_clk,
    input wire logic tx_bit_clk,
    input wire logic clear,
    // Bits taken in the window
    output logic [15:0] rx_bits,
    output logic [15:0] tx_bits
);
    logic rx_q;
    logic tx_q;
    // A bit is taken on each rising edge, so a pulse that never falls counts once only.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_q <= 1'b0;
            tx_q <= 1'b0;
            rx_bits <= 16'h0000;
            tx_bits <= 16'h0000;
        end else begin
            rx_q <= rx_bit_clk;
            tx_q <= tx_bit_clk;
            if (clear) begin
                rx_bits <= 16'h0000;
                tx_bits <= 16'h0000;
            end else begin
                rx_bits <= rx_bits + 16'(rx_bit_clk & !rx_q);
                tx_bits <= tx_bits + 16'(tx_bit_clk & !tx_q);
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/fractional_gapped_clock_control_bench.sv ====
/*
 Self-checking bench for the fractional gapped clock control block.
 Assumes a free-running 125 ns line clock shared by both directions.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fgc_params.svh"
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module fractional_gapped_clock_control_bench;
    import fgc_pkg::*;
    logic core_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    reg_byte_t reg_wdata = 8'h00, reg_rdata, rd;
    logic line_clk = 1'b0, frame_sync = 1'b0, rx_chan_select = 1'b0, tx_chan_select = 1'b0;
    line_mode_t line_mode = MODE_T1;
    logic [4:0] rx_next_channel, tx_next_channel;
    logic rx_pin, tx_pin, rx_cell, tx_cell, irq_out_n, tx_mf_sync, clr = 1'b0, rise_clr = 1'b0;
    logic irq_pending = 1'b0, es_mf_sync = 1'b0, framer_mf_sync = 1'b0, tx_sync_pin = 1'b0;
    logic [3:0] uo, rx_level_thresh;
    logic [31:0] rx_mask = 32'h00000000, tx_mask = 32'h00000000;
    logic [15:0] rx_bits, tx_bits;
    logic [7:0] rx_rises = 8'h00, tx_rises = 8'h00;
    logic rx_cell_q = 1'b0, tx_cell_q = 1'b0;
    // Gated framer clocks are held at opposite levels so a swapped source shows up.
    logic rx_gated = 1'b1, tx_gated = 1'b0;
    int bit_cnt = 0, error_cnt = 0, checks_done = 0;

    always #5 core_clk = ~core_clk;
    initial begin
        #3.3;
        forever #62.5 line_clk = ~line_clk;
    end
    // Frame sync is raised half a bit early so it is high across the rise of bit 0 only.
    always @(negedge line_clk) begin
        frame_sync <= (bit_cnt == ((line_mode == MODE_T1) ? 192 : 255));
        bit_cnt <= (bit_cnt >= ((line_mode == MODE_T1) ? 192 : 255)) ? 0 : bit_cnt + 1;
    end
    always @(negedge core_clk) begin
        rx_chan_select <= rx_mask[rx_next_channel];
        tx_chan_select <= tx_mask[tx_next_channel];
    end
    always @(posedge core_clk) begin
        rx_cell_q <= rx_cell;
        tx_cell_q <= tx_cell;
        rx_rises <= rise_clr ? 8'h00 : rx_rises + 8'(rx_cell & !rx_cell_q);
        tx_rises <= rise_clr ? 8'h00 : tx_rises + 8'(tx_cell & !tx_cell_q);
    end

    fractional_gapped_clock_control u_dut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_line_clock(line_clk), .tx_line_clock(line_clk), .rx_frame_sync(frame_sync),
        .tx_frame_sync(frame_sync), .line_mode(line_mode), .rx_chan_select(rx_chan_select),
        .tx_chan_select(tx_chan_select), .rx_next_channel(rx_next_channel),
        .tx_next_channel(tx_next_channel), .rx_channel_clock_pin(rx_pin), .tx_channel_clock_pin(tx_pin),
        .rx_framer_gated_clock(rx_gated), .tx_framer_gated_clock(tx_gated), .rx_cell_bus_clock(rx_cell),
        .tx_cell_bus_clock(tx_cell), .irq_pending(irq_pending), .irq_out_n(irq_out_n),
        .es_mf_sync(es_mf_sync), .framer_mf_sync(framer_mf_sync), .tx_sync_pin(tx_sync_pin),
        .tx_mf_sync(tx_mf_sync), .user_out_bit0(uo[0]), .user_out_bit1(uo[1]), .user_out_bit2(uo[2]),
        .user_out_bit3(uo[3]), .rx_level_thresh(rx_level_thresh)
    );
    serial_ctrl_model u_far (
        .core_clk(core_clk), .reset_n(reset_n), .rx_bit_clk(rx_pin), .tx_bit_clk(tx_pin),
        .clear(clr), .rx_bits(rx_bits), .tx_bits(tx_bits)
    );

    task automatic reg_wr(input logic [7:0] a, input reg_byte_t d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge core_clk);
        reg_write = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output reg_byte_t d);
        @(negedge core_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge core_clk);
        reg_read = 1'b0;
        d = reg_rdata;
    endtask
    task automatic do_reset();
        reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        `CHECK(uo, 4'h0)
        reg_rd(`FGC_GCC_OFFSET, rd);
        `CHECK(rd, `FGC_GCC_RESET)
        reg_rd(`FGC_UOC_OFFSET, rd);
        `CHECK(rd, `FGC_UOC_RESET)
    endtask
    task automatic cell_case(input reg_byte_t g, input logic rx_on, input logic tx_on);
        reg_wr(`FGC_GCC_OFFSET, g);
        repeat (5) @(negedge core_clk);
        rise_clr = 1'b1;
        @(negedge core_clk);
        rise_clr = 1'b0;
        repeat (100) @(negedge core_clk);
        `CHECK(rx_on ? (rx_rises inside {[8'h7:8'h9]}) : (rx_rises === 8'h00 && rx_cell === rx_gated), 1'b1)
        `CHECK(tx_on ? (tx_rises inside {[8'h7:8'h9]}) : (tx_rises === 8'h00 && tx_cell === tx_gated), 1'b1)
    endtask
    function automatic logic [15:0] exp_bits(input line_mode_t m, input logic gap, input logic f56,
                                             input logic [31:0] mask);
        logic [31:0] valid;
        valid = (m == MODE_T1) ? 32'h00FFFFFF : 32'hFFFFFFFF;
        if (!gap) return (m == MODE_T1) ? 16'h0030 : 16'h0040;
        return 16'($countones(mask & valid)) * (f56 ? 16'h000E : 16'h0010);
    endfunction
    // Counts are taken over two whole frames after two frames of settling.
    task automatic run_gap(input line_mode_t m, input reg_byte_t g, input logic [31:0] rm, input logic [31:0] tm);
        line_mode = m;
        rx_mask = rm;
        tx_mask = tm;
        reg_wr(`FGC_GCC_OFFSET, g);
        repeat (2) @(posedge frame_sync);
        @(negedge core_clk);
        clr = 1'b1;
        @(negedge core_clk);
        clr = 1'b0;
        repeat (2) @(posedge frame_sync);
        @(negedge core_clk);
        `CHECK(rx_bits, exp_bits(m, g[`FGC_RX_GAP_EN_BIT], g[`FGC_RX_FMT_BIT], rm))
        `CHECK(tx_bits, exp_bits(m, g[`FGC_TX_GAP_EN_BIT], g[`FGC_TX_FMT_BIT], tm))
    endtask
    task report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        // Four runs of up to four frames each need about 460 us; leave margin.
        #700000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        do_reset();
        reg_wr(`FGC_GCC_OFFSET, 8'hA5);
        reg_wr(8'h74, 8'hFF);
        reg_rd(`FGC_GCC_OFFSET, rd);
        `CHECK(rd, 8'hA5)
        reg_rd(8'h74, rd);
        `CHECK(rd, `FGC_UNMAPPED_READ)
        for (int i = 0; i < 16; i++) begin
            // The last pass leaves the user pins high, so the reset that follows must clear them.
            reg_wr(`FGC_UOC_OFFSET, {~4'(i), 4'(i)});
            repeat (2) @(negedge core_clk);
            `CHECK(uo, 4'(i))
            `CHECK(rx_level_thresh, ~4'(i))
        end
        do_reset();
        irq_pending = 1'b1;
        reg_wr(`FGC_GCC_OFFSET, 8'h80);
        repeat (2) @(negedge core_clk);
        `CHECK(irq_out_n, 1'b0)
        reg_wr(`FGC_GCC_OFFSET, 8'hC0);
        repeat (2) @(negedge core_clk);
        `CHECK(irq_out_n, 1'b1)
        irq_pending = 1'b0;
        reg_wr(`FGC_GCC_OFFSET, 8'h80);
        repeat (2) @(negedge core_clk);
        `CHECK(irq_out_n, 1'b1)
        cell_case(8'h90, 1'b1, 1'b0);
        cell_case(8'hA0, 1'b0, 1'b1);
        {rx_gated, tx_gated} = 2'b01;
        cell_case(8'h90, 1'b1, 1'b0);
        cell_case(8'hA0, 1'b0, 1'b1);
        for (int i = 0; i < 16; i++) begin
            {es_mf_sync, framer_mf_sync, tx_sync_pin} = 3'(i);
            reg_wr(`FGC_GCC_OFFSET, {i[3], 7'h00});
            repeat (6) @(negedge core_clk);
            `CHECK(tx_mf_sync, i[3] ? (framer_mf_sync | tx_sync_pin) : es_mf_sync)
        end
        run_gap(MODE_T1, 8'h80, 32'h00FFFFFF, 32'h00FFFFFF);
        run_gap(MODE_T1, 8'h8D, 32'h00800001, 32'h00000F0F);
        run_gap(MODE_E1, 8'h87, 32'h80000001, 32'hFFFF0000);
        run_gap(MODE_E1, 8'h80, 32'h00000000, 32'h00000000);
        report_and_stop();
    end
endmodule
`default_nettype wire
